/* hdl/pss_pkg.sv */
// shared constants, types and helpers of the phase sync and sysref block
package pss_pkg;
  // ********************
  // register map
  // ********************
  localparam logic [7:0] PSS_ADDR_CTRL = 8'h00;
  localparam logic [7:0] PSS_ADDR_OUTSEL = 8'h04;
  localparam logic [7:0] PSS_ADDR_SEED = 8'h08;
  localparam logic [7:0] PSS_ADDR_MOD = 8'h0C;
  localparam logic [7:0] PSS_ADDR_SYSREF = 8'h10;
  localparam logic [7:0] PSS_ADDR_DELAY = 8'h14;
  localparam logic [7:0] PSS_ADDR_STATUS = 8'h18;
  localparam logic [7:0] PSS_ADDR_PHASE = 8'h1C;
  // ********************
  // output selector codes
  // ********************
  localparam logic [1:0] PSS_SEL_OUTPUT_DIVIDE_RATIO = 2'h0;
  localparam logic [1:0] PSS_SEL_VCO = 2'h1;
  localparam logic [1:0] PSS_SEL_SYSREF = 2'h2;
  // ********************
  // reset values and fixed figures
  // ********************
  localparam logic [3:0] PSS_BURST_LEN_RST = 4'h4;
  localparam logic [2:0] PSS_PRESCALE_RST = 3'h1;
  localparam logic [3:0] PSS_DIVIDER_STAGE_ONE_RST = 4'h2;
  localparam logic [1:0] PSS_OUT_SEL_RST = 2'h1;
  localparam logic [23:0] PSS_DEN_RST = 24'h00_0001;
  localparam logic [5:0] PSS_TAP1_RST = 6'h24;
  localparam logic [5:0] PSS_TAP2_RST = 6'h1B;
  localparam logic [5:0] PSS_TAP_SUM = 6'h3F;
  localparam logic [7:0] PSS_DELAY_MAX = 8'hF7;
  localparam logic [12:0] PSS_RATE_BASE = 13'h0004;
  // ********************
  // carried fields
  // ********************
  typedef struct packed {
    logic phase_sync_mode;
    logic input_pin_disregard;
    logic modulator_reset_n;
    logic sysref_gen_on;
    logic sysref_echo_mode;
    logic sysref_burst_mode;
  } pss_ctrl_t;

  typedef struct packed {
    logic [2:0] sysref_prescale;
    logic [10:0] sysref_rate_ratio;
    logic [3:0] sysref_burst_len;
  } pss_sysref_t;

  typedef struct packed {
    logic [5:0] delay_tap_word1;
    logic [5:0] delay_tap_word2;
    logic [5:0] delay_tap_word3;
    logic [5:0] delay_tap_word4;
  } pss_taps_t;

  // delay code from the four tap words, bit 8 flags an invalid set
  function automatic logic [8:0] pss_delay_code(input pss_taps_t t);
    logic [7:0] c;
    logic bad;
    c = 8'h00;
    bad = 1'b0;
    if ((t.delay_tap_word1 + t.delay_tap_word2 + t.delay_tap_word3
        + t.delay_tap_word4) != {2'b00, PSS_TAP_SUM}) begin
      bad = 1'b1;
    end else if (t.delay_tap_word3 == 6'h00 && t.delay_tap_word4 == 6'h00)
    begin
      if (t.delay_tap_word2 >= 6'h1B) begin
        c = {2'b00, t.delay_tap_word2} - 8'h1B;
      end else if (t.delay_tap_word2 <= 6'h16) begin
        c = {2'b00, t.delay_tap_word2} + 8'hE1;
      end else begin
        bad = 1'b1;
      end
    end else if (t.delay_tap_word1 == 6'h00 && t.delay_tap_word4 == 6'h00)
    begin
      c = {2'b00, t.delay_tap_word3} + 8'h24;
    end else if (t.delay_tap_word1 == 6'h00 && t.delay_tap_word2 == 6'h00)
    begin
      c = {2'b00, t.delay_tap_word4} + 8'h63;
    end else if (t.delay_tap_word2 == 6'h00 && t.delay_tap_word3 == 6'h00)
    begin
      c = {2'b00, t.delay_tap_word1} + 8'hA2;
    end else begin
      bad = 1'b1;
    end
    if (c > PSS_DELAY_MAX) begin
      bad = 1'b1;
    end
    return {bad, c};
  endfunction : pss_delay_code
endpackage : pss_pkg

/* hdl/pss_tick_div.sv */
// enable-pulse divider: one tick every div enabled cycles
`timescale 1ns/1ps
`default_nettype none
module pss_tick_div
  import pss_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic en_in,
  input wire logic [W-1:0] div_in,
  // tick
  output logic tick_out
);
  logic [W-1:0] cnt_ff;
  logic tick_ff;

  // a zero divide stops the ticks rather than running free
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (!en_in || div_in == '0) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (cnt_ff >= div_in - W'(1)) begin
      cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + W'(1);
      tick_ff <= 1'b0;
    end
  end

  assign tick_out = tick_ff;
endmodule : pss_tick_div
`default_nettype wire

/* hdl/pss_core.sv */
// phase sync, seed phase adjust and sysref generation
`timescale 1ns/1ps
`default_nettype none
module pss_core
  import pss_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rd_data_out,
  // pins
  input wire logic sync_pin_in,
  input wire logic sysref_request_pin_in,
  // results
  output logic sysref_out,
  output logic sync_event_out,
  output logic [7:0] sysref_delay_code_out,
  output logic [4:0] feedback_included_ratio_out
);
  // ********************
  // reset release
  // ********************
  logic rst_meta_ff;
  logic rst_n_ff;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ********************
  // registers
  // ********************
  pss_ctrl_t ctrl_ff;
  pss_sysref_t sref_ff;
  pss_taps_t taps_ff;
  logic [1:0] out_a_select_ff;
  logic [1:0] out_b_select_ff;
  logic [3:0] divider_stage_one_ff;
  logic [4:0] output_divide_ratio_ff;
  logic [23:0] frac_denominator_ff;
  logic [1:0] modulator_order_ff;
  logic wr_ctrl;
  logic wr_sref;
  assign wr_ctrl = wr_in && addr_in == PSS_ADDR_CTRL;
  assign wr_sref = wr_in && addr_in == PSS_ADDR_SYSREF;

  always_ff @(posedge clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ctrl_ff <= '{phase_sync_mode: 1'b0, input_pin_disregard: 1'b1,
                   modulator_reset_n: 1'b1, default: 1'b0};
    end else if (wr_ctrl) begin
      ctrl_ff <= pss_ctrl_t'(wr_data_in[5:0]);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      out_a_select_ff <= PSS_OUT_SEL_RST;
      out_b_select_ff <= PSS_OUT_SEL_RST;
      divider_stage_one_ff <= PSS_DIVIDER_STAGE_ONE_RST;
      output_divide_ratio_ff <= 5'h00;
      frac_denominator_ff <= PSS_DEN_RST;
      modulator_order_ff <= 2'h0;
      sref_ff <= '{sysref_prescale: PSS_PRESCALE_RST,
                   sysref_rate_ratio: 11'h000,
                   sysref_burst_len: PSS_BURST_LEN_RST};
      taps_ff <= '{delay_tap_word1: PSS_TAP1_RST,
                   delay_tap_word2: PSS_TAP2_RST, default: 6'h00};
    end else if (wr_in) begin
      case (addr_in)
        PSS_ADDR_OUTSEL: begin
          out_a_select_ff <= wr_data_in[1:0];
          out_b_select_ff <= wr_data_in[5:4];
          divider_stage_one_ff <= wr_data_in[11:8];
          output_divide_ratio_ff <= wr_data_in[20:16];
        end
        PSS_ADDR_MOD: begin
          frac_denominator_ff <= wr_data_in[23:0];
          modulator_order_ff <= wr_data_in[25:24];
        end
        PSS_ADDR_SYSREF: begin
          sref_ff <= '{sysref_prescale: wr_data_in[2:0],
                       sysref_rate_ratio: wr_data_in[18:8],
                       sysref_burst_len: wr_data_in[23:20]};
        end
        PSS_ADDR_DELAY: begin
          taps_ff <= pss_taps_t'(wr_data_in[23:0]);
        end
        default: begin
        end
      endcase
    end
  end

  // ********************
  // included divide
  // ********************
  logic uses_output_divide_ratio;
  logic [4:0] included_ratio;
  logic [4:0] eff_ratio;
  assign uses_output_divide_ratio = out_a_select_ff == PSS_SEL_OUTPUT_DIVIDE_RATIO
                   || out_b_select_ff == PSS_SEL_OUTPUT_DIVIDE_RATIO
                   || out_b_select_ff == PSS_SEL_SYSREF;
  assign included_ratio = !uses_output_divide_ratio ? 5'h01
                        : output_divide_ratio_ff == 5'h00 ? 5'h04
                        : {divider_stage_one_ff, 1'b0};
  assign eff_ratio = ctrl_ff.phase_sync_mode ? included_ratio : 5'h01;

  // ********************
  // sync events
  // ********************
  // the first enable after reset only arms; later 0 to 1 toggles sync
  logic sync_armed_ff;
  logic pin_prev_ff;
  logic sw_sync;
  logic pin_sync;
  logic sync_evt;
  assign sw_sync = wr_ctrl && wr_data_in[5] && !ctrl_ff.phase_sync_mode
                && sync_armed_ff;
  assign pin_sync = sync_pin_in && !pin_prev_ff && ctrl_ff.phase_sync_mode
                 && !ctrl_ff.input_pin_disregard;
  assign sync_evt = sw_sync || pin_sync;

  always_ff @(posedge clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sync_armed_ff <= 1'b0;
      pin_prev_ff <= 1'b0;
      sync_event_out <= 1'b0;
    end else begin
      pin_prev_ff <= sync_pin_in;
      sync_event_out <= sync_evt;
      if (ctrl_ff.phase_sync_mode) begin
        sync_armed_ff <= 1'b1;
      end
    end
  end

  // ********************
  // seed phase accumulator
  // ********************
  logic [31:0] phase_acc_ff;
  logic seed_ok;
  logic [31:0] seed_rem;
  assign seed_rem = frac_denominator_ff == 24'h00_0000 ? 32'h0000_0000
                  : wr_data_in % {8'h00, frac_denominator_ff};
  assign seed_ok = modulator_order_ff != 2'h0
                && (modulator_order_ff != 2'h1
                    || seed_rem == 32'h0000_0000);

  always_ff @(posedge clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      phase_acc_ff <= 32'h0000_0000;
    end else if (sync_evt || !ctrl_ff.modulator_reset_n) begin
      phase_acc_ff <= 32'h0000_0000;
    end else if (wr_in && addr_in == PSS_ADDR_SEED && seed_ok) begin
      phase_acc_ff <= phase_acc_ff + wr_data_in;
    end
  end

  // ********************
  // interpolator tick and request resampling
  // ********************
  logic pre_ok;
  logic interp_tick;
  logic [7:0] interp_div;
  assign pre_ok = sref_ff.sysref_prescale == 3'h1
               || sref_ff.sysref_prescale == 3'h2
               || sref_ff.sysref_prescale == 3'h4;
  assign interp_div = 8'({3'b000, eff_ratio}
                      * {5'h00, sref_ff.sysref_prescale});

  pss_tick_div #(.W(8)) u_interp (
    .clk_in(clk_in),
    .rst_n_in(rst_n_ff),
    .en_in(pre_ok && ctrl_ff.sysref_gen_on),
    .div_in(interp_div),
    .tick_out(interp_tick)
  );

  logic req_s_ff;
  always_ff @(posedge clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      req_s_ff <= 1'b0;
    end else if (interp_tick) begin
      req_s_ff <= sysref_request_pin_in;
    end
  end

  // ********************
  // pulse generation
  // ********************
  // sysref runs only with sync mode set; the host orders the two writes
  logic gen_ok;
  logic gen_prev_ff;
  logic [12:0] rate_div;
  logic [12:0] rate_cnt_ff;
  logic master_lvl_ff;
  logic [3:0] burst_left_ff;
  logic nxt_sysref;
  logic burst_done;
  assign gen_ok = ctrl_ff.sysref_gen_on && ctrl_ff.phase_sync_mode && pre_ok;
  assign rate_div = PSS_RATE_BASE
                  + {1'b0, sref_ff.sysref_rate_ratio, 1'b0};
  assign burst_done = ctrl_ff.sysref_burst_mode && burst_left_ff == 4'h0;

  // master: level toggles every rate_div ticks, period twice that
  always_ff @(posedge clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rate_cnt_ff <= 13'h0000;
      master_lvl_ff <= 1'b0;
    end else if (!gen_ok || ctrl_ff.sysref_echo_mode || !req_s_ff
                 || (burst_done && !master_lvl_ff)) begin
      rate_cnt_ff <= 13'h0000;
      master_lvl_ff <= 1'b0;
    end else if (interp_tick) begin
      if (rate_cnt_ff >= rate_div - 13'h0001) begin
        rate_cnt_ff <= 13'h0000;
        master_lvl_ff <= !master_lvl_ff;
      end else begin
        rate_cnt_ff <= rate_cnt_ff + 13'h0001;
      end
    end
  end

  always_comb begin
    if (!gen_ok) begin
      nxt_sysref = 1'b0;
    end else if (ctrl_ff.sysref_echo_mode) begin
      nxt_sysref = req_s_ff && (!burst_done || sysref_out);
    end else begin
      nxt_sysref = master_lvl_ff;
    end
  end

  // burst count reloads on enable or a sysref write, one per pulse end
  always_ff @(posedge clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      gen_prev_ff <= 1'b0;
      burst_left_ff <= PSS_BURST_LEN_RST;
    end else begin
      gen_prev_ff <= gen_ok;
      if ((gen_ok && !gen_prev_ff) || wr_sref) begin
        burst_left_ff <= wr_sref ? wr_data_in[23:20]
                       : sref_ff.sysref_burst_len;
      end else if (sysref_out && !nxt_sysref && burst_left_ff != 4'h0) begin
        burst_left_ff <= burst_left_ff - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sysref_out <= 1'b0;
    end else begin
      sysref_out <= nxt_sysref;
    end
  end

  // ********************
  // delay code and included divide outputs
  // ********************
  logic [8:0] delay_word;
  logic delay_bad_ff;
  assign delay_word = pss_delay_code(taps_ff);
  always_ff @(posedge clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sysref_delay_code_out <= 8'h00;
      delay_bad_ff <= 1'b0;
      feedback_included_ratio_out <= 5'h01;
    end else begin
      // an invalid tap set keeps the last good code on the output
      if (!delay_word[8]) begin
        sysref_delay_code_out <= delay_word[7:0];
      end
      delay_bad_ff <= delay_word[8];
      feedback_included_ratio_out <= eff_ratio;
    end
  end

  // ********************
  // read port
  // ********************
  logic [31:0] rd_mux;
  always_comb begin
    case (addr_in)
      PSS_ADDR_CTRL: rd_mux = {26'h000_0000, ctrl_ff};
      PSS_ADDR_OUTSEL: rd_mux = {11'h000, output_divide_ratio_ff,
                                 4'h0, divider_stage_one_ff, 2'h0,
                                 out_b_select_ff, 2'h0, out_a_select_ff};
      PSS_ADDR_MOD: rd_mux = {6'h00, modulator_order_ff,
                              frac_denominator_ff};
      PSS_ADDR_SYSREF: rd_mux = {8'h00, sref_ff.sysref_burst_len, 1'b0,
                                 sref_ff.sysref_rate_ratio, 5'h00,
                                 sref_ff.sysref_prescale};
      PSS_ADDR_DELAY: rd_mux = {8'h00, taps_ff};
      PSS_ADDR_STATUS: rd_mux = {8'h00, burst_left_ff, 2'h0,
                                 !pre_ok, delay_bad_ff, sysref_out,
                                 sync_armed_ff, 1'b0, eff_ratio,
                                 sysref_delay_code_out};
      PSS_ADDR_PHASE: rd_mux = phase_acc_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rd_data_out <= 32'h0000_0000;
    end else begin
      rd_data_out <= rd_in ? rd_mux : 32'h0000_0000;
    end
  end
endmodule : pss_core
`default_nettype wire

/* verification/pss_core_checker.sv */
// port checker of the phase sync and sysref block
`timescale 1ns/1ps
`default_nettype none
module pss_core_checker
  import pss_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rd_data_out,
  // pins and results
  input wire logic sync_pin_in,
  input wire logic sysref_request_pin_in,
  input wire logic sysref_out,
  input wire logic sync_event_out,
  input wire logic [7:0] sysref_delay_code_out,
  input wire logic [4:0] feedback_included_ratio_out
);
  // ********************
  // shadow of control fields
  // ********************
  logic [5:0] ctrl_ff;
  logic [2:0] pre_ff;
  logic armed_ff;
  logic pre_bad;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_ff <= 6'h18;
    end else if (wr_in && addr_in == PSS_ADDR_CTRL) begin
      ctrl_ff <= wr_data_in[5:0];
    end
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pre_ff <= PSS_PRESCALE_RST;
    end else if (wr_in && addr_in == PSS_ADDR_SYSREF) begin
      pre_ff <= wr_data_in[2:0];
    end
  end
  // first enable since reset only arms
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      armed_ff <= 1'b0;
    end else if (ctrl_ff[5]) begin
      armed_ff <= 1'b1;
    end
  end
  assign pre_bad = pre_ff != 3'h1 && pre_ff != 3'h2 && pre_ff != 3'h4;
  // ********************
  // assertions
  // ********************
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_rd_idle_zero: assert property (!$past(rd_in) |-> rd_data_out == 32'h0)
    else $error("read data not zero outside read answer");
  a_pin_sync_event: assert property (
    $rose(sync_pin_in) && ctrl_ff[5] && !ctrl_ff[4] |-> ##[1:2] sync_event_out)
    else $error("pin rise gave no sync event");
  a_arm_no_event: assert property (
    wr_in && addr_in == PSS_ADDR_CTRL && wr_data_in[5] && !ctrl_ff[5]
    && !armed_ff && !$rose(sync_pin_in) |=> !sync_event_out [*2])
    else $error("arming write counted as sync");
  a_event_single: assert property (sync_event_out |=> !sync_event_out)
    else $error("sync event longer than one cycle");
  a_ratio_off_one: assert property (
    !ctrl_ff[5] |=> feedback_included_ratio_out == 5'h01)
    else $error("included ratio not 1 with sync mode off");
  a_delay_max: assert property (sysref_delay_code_out <= PSS_DELAY_MAX)
    else $error("delay code above maximum");
  a_delay_on_write: assert property (
    $changed(sysref_delay_code_out) |-> $past(wr_in && addr_in ==
    PSS_ADDR_DELAY) || $past(wr_in && addr_in == PSS_ADDR_DELAY, 2))
    else $error("delay code moved without a tap write");
  a_sysref_gated: assert property (
    (!(ctrl_ff[2] && ctrl_ff[5])) [*6] |-> !sysref_out)
    else $error("sysref active while disabled");
  a_prescale_quiet: assert property (pre_bad [*6] |-> !sysref_out)
    else $error("sysref active with invalid prescale");
endmodule : pss_core_checker
bind pss_core pss_core_checker u_pss_core_checker (
  .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
  .rd_data_out(rd_data_out), .sync_pin_in(sync_pin_in),
  .sysref_request_pin_in(sysref_request_pin_in), .sysref_out(sysref_out),
  .sync_event_out(sync_event_out),
  .sysref_delay_code_out(sysref_delay_code_out),
  .feedback_included_ratio_out(feedback_included_ratio_out));
`default_nettype wire

/* verification/pss_conv_model.sv */
// converter model: counts sysref rises and the last period
`timescale 1ns/1ps
`default_nettype none
module pss_conv_model (
  // clock
  input wire logic clk_in,
  // reference pulse
  input wire logic sysref_in,
  // observations
  output int rise_cnt_out,
  output int period_out
);
  bit last_ff;
  int since_ff;
  // receiver only; it never loads the line
  always_ff @(posedge clk_in) begin
    last_ff <= sysref_in === 1'b1;
    if (sysref_in === 1'b1 && !last_ff) begin
      rise_cnt_out <= rise_cnt_out + 1;
      period_out <= since_ff;
      since_ff <= 1;
    end else begin
      since_ff <= since_ff + 1;
    end
  end
endmodule : pss_conv_model
`default_nettype wire

/* verification/pss_core_test.sv */
// register-level tests of the phase sync and sysref block
`timescale 1ns/1ps
`default_nettype none
module pss_core_test;
  import pss_pkg::*;
  logic clk_in, resetn_in, wr_in, rd_in, sync_pin_in, req_in;
  logic [7:0] addr_in;
  logic [31:0] wr_data_in, rd_data_out;
  logic sysref_out, sync_event_out;
  logic [7:0] code_out;
  logic [4:0] ratio_out;
  int err_count, n_checks, ev_cnt, rise_cnt, period, r0, e0;
  pss_core u_pss_core (.clk_in(clk_in), .resetn_in(resetn_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
    .rd_in(rd_in), .rd_data_out(rd_data_out), .sync_pin_in(sync_pin_in),
    .sysref_request_pin_in(req_in), .sysref_out(sysref_out),
    .sync_event_out(sync_event_out), .sysref_delay_code_out(code_out),
    .feedback_included_ratio_out(ratio_out));
  pss_conv_model u_pss_conv_model (.clk_in(clk_in), .sysref_in(sysref_out),
    .rise_cnt_out(rise_cnt), .period_out(period));
  // ********************
  // bus and check tasks
  // ********************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
    chk(rd_data_out & m, e);
  endtask : rchk
  task automatic rcase(input logic [31:0] w, input logic [4:0] e);
    wr(PSS_ADDR_OUTSEL, w);
    cyc(3);
    chk(32'(ratio_out), 32'(e));
  endtask : rcase
  // period 0 means no pulse may rise in the second 200 cycles
  task automatic scase(input logic [31:0] w, input int e);
    wr(PSS_ADDR_SYSREF, w);
    cyc(200);
    r0 = rise_cnt;
    cyc(200);
    if (e != 0) chk(32'(period), 32'(e));
    else chk(32'(rise_cnt - r0), 32'h0);
  endtask : scase
  task automatic dcase(input logic [31:0] w, input logic [7:0] e);
    wr(PSS_ADDR_DELAY, w);
    cyc(3);
    chk(32'(code_out), 32'(e));
  endtask : dcase
  task automatic sync_chk(input int n);
    cyc(4);
    chk(32'(ev_cnt - e0), 32'(n));
    e0 = ev_cnt;
  endtask : sync_chk
  task automatic results;
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  // ********************
  // clock, watchdog, event counter
  // ********************
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    #(25ns * 20000);
    err_count++;
    results();
  end
  always @(posedge clk_in) if (sync_event_out === 1'b1) ev_cnt++;
  // ********************
  // main sequence
  // ********************
  initial begin
    {resetn_in, wr_in, rd_in, sync_pin_in, req_in} = 5'h00;
    addr_in = 8'h00;
    wr_data_in = 32'h0;
    cyc(12);
    resetn_in <= 1'b1;
    cyc(3);
    chk(32'(ratio_out), 32'h0000_0001);
    rchk(PSS_ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0018);
    rchk(PSS_ADDR_OUTSEL, 32'h0000_0F33, 32'h0000_0211);
    rchk(PSS_ADDR_SYSREF, 32'hFFFF_FFFF, 32'h0040_0001);
    rchk(PSS_ADDR_DELAY, 32'hFFFF_FFFF, 32'h0091_B000);
    rchk(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
    // sync arming, seeds and phase clearing
    e0 = ev_cnt;
    wr(PSS_ADDR_MOD, 32'h0200_000C);
    wr(PSS_ADDR_CTRL, 32'h0000_0028);
    sync_chk(0);
    wr(PSS_ADDR_SEED, 32'h0000_0005);
    wr(PSS_ADDR_SEED, 32'h0000_0007);
    rchk(PSS_ADDR_PHASE, 32'hFFFF_FFFF, 32'h0000_000C);
    sync_pin_in <= 1'b1;
    sync_chk(1);
    rchk(PSS_ADDR_PHASE, 32'hFFFF_FFFF, 32'h0000_0000);
    sync_pin_in <= 1'b0;
    wr(PSS_ADDR_SEED, 32'h0000_0003);
    wr(PSS_ADDR_CTRL, 32'h0000_0018);
    wr(PSS_ADDR_CTRL, 32'h0000_0028);
    sync_chk(1);
    rchk(PSS_ADDR_PHASE, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(PSS_ADDR_SEED, 32'h0000_0004);
    wr(PSS_ADDR_CTRL, 32'h0000_0020);
    rchk(PSS_ADDR_PHASE, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(PSS_ADDR_CTRL, 32'h0000_0028);
    wr(PSS_ADDR_MOD, 32'h0100_000C);
    wr(PSS_ADDR_SEED, 32'h0000_0005);
    rchk(PSS_ADDR_PHASE, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(PSS_ADDR_SEED, 32'h0000_0018);
    rchk(PSS_ADDR_PHASE, 32'hFFFF_FFFF, 32'h0000_0018);
    wr(PSS_ADDR_MOD, 32'h0000_000C);
    wr(PSS_ADDR_SEED, 32'h0000_000C);
    rchk(PSS_ADDR_PHASE, 32'hFFFF_FFFF, 32'h0000_0018);
    // included divide against output selection
    rcase(32'h0005_0311, 5'h01);
    rcase(32'h0005_0310, 5'h06);
    rcase(32'h0005_0301, 5'h06);
    rcase(32'h0005_0221, 5'h04);
    rcase(32'h0005_0312, 5'h01);
    rcase(32'h0000_0301, 5'h04);
    wr(PSS_ADDR_CTRL, 32'h0000_0018);
    cyc(3);
    chk(32'(ratio_out), 32'h0000_0001);
    // master continuous: ratio 2, period 2*(4+2*code)*2*prescale
    wr(PSS_ADDR_OUTSEL, 32'h0005_0121);
    wr(PSS_ADDR_CTRL, 32'h0000_0028);
    wr(PSS_ADDR_CTRL, 32'h0000_002C);
    req_in <= 1'b1;
    scase(32'h0040_0001, 16);
    scase(32'h0040_0102, 48);
    scase(32'h0040_0204, 128);
    scase(32'h0040_0003, 0);
    // bursts of three and of zero pulses
    wr(PSS_ADDR_CTRL, 32'h0000_0029);
    wr(PSS_ADDR_SYSREF, 32'h0030_0001);
    r0 = rise_cnt;
    wr(PSS_ADDR_CTRL, 32'h0000_002D);
    cyc(300);
    chk(32'(rise_cnt - r0), 32'h0000_0003);
    wr(PSS_ADDR_CTRL, 32'h0000_0029);
    wr(PSS_ADDR_SYSREF, 32'h0000_0001);
    r0 = rise_cnt;
    wr(PSS_ADDR_CTRL, 32'h0000_002D);
    cyc(300);
    chk(32'(rise_cnt - r0), 32'h0000_0000);
    // repeater follows both request edges
    req_in <= 1'b0;
    wr(PSS_ADDR_CTRL, 32'h0000_002E);
    cyc(20);
    r0 = rise_cnt;
    repeat (3) begin
      req_in <= 1'b1;
      cyc(20);
      chk(32'(sysref_out), 32'h0000_0001);
      req_in <= 1'b0;
      cyc(20);
      chk(32'(sysref_out), 32'h0000_0000);
    end
    chk(32'(rise_cnt - r0), 32'h0000_0003);
    // delay code from tap words; a bad set keeps the last code
    dcase(32'h0003_E040, 8'h25);
    dcase(32'h00A5_6000, 8'hF7);
    dcase(32'h0004_003E, 8'hA3);
    dcase(32'h0028_A000, 8'hA3);
    dcase(32'h00FC_0000, 8'hE1);
    dcase(32'h0000_0F81, 8'h64);
    results();
  end
endmodule : pss_core_test
`default_nettype wire
